// >>> design/vlm_consts.svh
// Offsets, field positions and reset values of the VME register block.
`ifndef VLM_CONSTS_SVH
`define VLM_CONSTS_SVH

// Byte offsets in processor I/O space.
`define VLM_OFS_CTRL 16'h1000
`define VLM_OFS_STATUS 16'h1001
`define VLM_OFS_BASE_HI 16'h1002
`define VLM_OFS_BASE_LO 16'h1003
`define VLM_OFS_SEM_ONE 16'h1004
`define VLM_OFS_SEM_TWO 16'h1005
`define VLM_OFS_SLOT 16'h1006

// Control register bits: set in the upper nibble, clear in the lower.
`define VLM_CTL_SET_SOFT_1 7
`define VLM_CTL_SET_SOFT_0 6
`define VLM_CTL_SET_HIT_1 5
`define VLM_CTL_SET_HIT_0 4
`define VLM_CTL_CLR_SOFT_1 3
`define VLM_CTL_CLR_SOFT_0 2
`define VLM_CTL_CLR_HIT_1 1
`define VLM_CTL_CLR_HIT_0 0

// Monitor enable bit within the lower base register.
`define VLM_LO_ENABLE 3
// Semaphore lock bit.
`define VLM_SEM_LOCK 7
// Monitor hit offsets within the 16-byte window.
`define VLM_HIT_OFS_1 4'h3
`define VLM_HIT_OFS_0 4'h1

// Reset values and fill.
`define VLM_RST_BYTE 8'h00
`define VLM_RST_NIBBLE 4'h0
`define VLM_READ_FILL 2'h0

`endif

// >>> design/vlm_pkg.sv
// Types shared by the VME location monitor and semaphore block.
package vlm_pkg;

  // One byte-wide I/O request from the processor or the bridge image.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } vlm_io_req_s;

  // One VMEbus address cycle seen by the location monitor.
  typedef struct packed {
    logic strobe;
    logic [15:0] addr;
  } vlm_vme_probe_s;

  // The four flags in their status-register order.
  typedef struct packed {
    logic soft_signal_flag_1;
    logic soft_signal_flag_0;
    logic monitor_hit_flag_1;
    logic monitor_hit_flag_0;
  } vlm_flags_s;

endpackage : vlm_pkg

// >>> design/vlm_regs.sv
// VME signal flags, location monitor, semaphores and slot address.
//
// Summary of operation
// - Status byte: enables high, read-only flags low.
// - Signal 1 flag and enable drive interrupt 1.
// - Signal 0 flag and enable drive interrupt 0.
// - Monitor 1 flag and enable drive interrupt 1.
// - Monitor 0 flag and enable drive interrupt 0.
// - Signal flags set only by control writes, cleared by them or reset.
// - Offset 3 hit or set bit sets monitor 1.
// - Offset 1 hit or set bit sets monitor 0.
// - Monitor flags clear only by reset or clear.
// - Upper base register holds address bits 15:8.
// - Lower base register holds address bits 7:4.
// - Monitor hits only while its enable bit set.
// - Locked semaphore refuses writes with bit 7 set.
// - Two independent semaphores, both reset to zero.
// - Read-only slot register shows six backplane pins.
// - All registers also reachable through bridge image.
// - Control write sets or clears each flag.
`timescale 1ns/1ps
`include "vlm_consts.svh"

module vlm_regs (
  input wire logic clk, // 10 MHz system clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire vlm_pkg::vlm_io_req_s io_req, // Register read/write request.
  output logic [7:0] io_rdata, // Read data, held until next read.
  output logic io_rvalid, // One-cycle pulse marking io_rdata.
  input wire vlm_pkg::vlm_vme_probe_s vme_probe, // VMEbus access seen.
  input wire logic [5:0] slot_addr_n, // Slot parity and address, low.
  output logic irq_flag1, // Flag interrupt 1, active high.
  output logic irq_flag0 // Flag interrupt 0, active high.
);

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Semaphore update: a set lock bit refuses a value that also locks.
  function automatic logic [7:0] sem_update(
    input logic [7:0] cur,
    input logic [7:0] wval
  );
    if (cur[`VLM_SEM_LOCK] && wval[`VLM_SEM_LOCK]) begin
      sem_update = cur;
    end else begin
      sem_update = wval;
    end
  endfunction : sem_update

  // Next value of a flag: clear beats a software set, a hit beats both.
  function automatic logic flag_next(
    input logic cur,
    input logic set_bit,
    input logic clr_bit,
    input logic hit
  );
    flag_next = ((cur | set_bit) & ~clr_bit) | hit;
  endfunction : flag_next

  // Location monitor match at one offset of the 16-byte window.
  function automatic logic mon_match(
    input logic [15:0] addr,
    input logic [11:0] base,
    input logic [3:0] ofs
  );
    mon_match = (addr[15:4] == base) && (addr[3:0] == ofs);
  endfunction : mon_match

  ////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [3:0] irq_enable; // Signal 1, signal 0, monitor 1, monitor 0.
  vlm_pkg::vlm_flags_s flags;
  logic [7:0] monitor_base_high_bits;
  logic [3:0] monitor_base_low_bits;
  logic monitor_enable;
  logic [7:0] semaphore_value_one;
  logic [7:0] semaphore_value_two;
  logic [5:0] slot_sample;

  ////////////////////////////////////////////////////////////////////////
  // Address decode of the register port. Local and bridged accesses
  // arrive on the same port, so one decode serves both.

  wire wr_ctrl = io_req.wr && (io_req.addr == `VLM_OFS_CTRL);
  wire wr_status = io_req.wr && (io_req.addr == `VLM_OFS_STATUS);
  wire wr_base_hi = io_req.wr && (io_req.addr == `VLM_OFS_BASE_HI);
  wire wr_base_lo = io_req.wr && (io_req.addr == `VLM_OFS_BASE_LO);
  wire wr_sem_one = io_req.wr && (io_req.addr == `VLM_OFS_SEM_ONE);
  wire wr_sem_two = io_req.wr && (io_req.addr == `VLM_OFS_SEM_TWO);

  // Control strobes; a zero bit or a write elsewhere leaves flags alone.
  wire [7:0] ctl = wr_ctrl ? io_req.wdata : `VLM_RST_BYTE;
  wire set_soft_signal_1 = ctl[`VLM_CTL_SET_SOFT_1];
  wire set_soft_signal_0 = ctl[`VLM_CTL_SET_SOFT_0];
  wire set_monitor_hit_1 = ctl[`VLM_CTL_SET_HIT_1];
  wire set_monitor_hit_0 = ctl[`VLM_CTL_SET_HIT_0];
  wire clear_soft_signal_1 = ctl[`VLM_CTL_CLR_SOFT_1];
  wire clear_soft_signal_0 = ctl[`VLM_CTL_CLR_SOFT_0];
  wire clear_monitor_hit_1 = ctl[`VLM_CTL_CLR_HIT_1];
  wire clear_monitor_hit_0 = ctl[`VLM_CTL_CLR_HIT_0];

  ////////////////////////////////////////////////////////////////////////
  // Location monitor. The base compare uses the live registers, so a
  // hit in the same cycle as a base write matches the old base.

  wire [11:0] mon_base = {monitor_base_high_bits, monitor_base_low_bits};
  wire mon_live = vme_probe.strobe && monitor_enable;
  wire hit_1 = mon_live &&
    mon_match(vme_probe.addr, mon_base, `VLM_HIT_OFS_1);
  wire hit_0 = mon_live &&
    mon_match(vme_probe.addr, mon_base, `VLM_HIT_OFS_0);

  // Flag next values; signal flags take no monitor input at all.
  vlm_pkg::vlm_flags_s next_flags;
  assign next_flags.soft_signal_flag_1 = flag_next(
    flags.soft_signal_flag_1, set_soft_signal_1, clear_soft_signal_1,
    1'b0);
  assign next_flags.soft_signal_flag_0 = flag_next(
    flags.soft_signal_flag_0, set_soft_signal_0, clear_soft_signal_0,
    1'b0);
  assign next_flags.monitor_hit_flag_1 = flag_next(
    flags.monitor_hit_flag_1, set_monitor_hit_1, clear_monitor_hit_1,
    hit_1);
  assign next_flags.monitor_hit_flag_0 = flag_next(
    flags.monitor_hit_flag_0, set_monitor_hit_0, clear_monitor_hit_0,
    hit_0);

  // Interrupt terms, one per output.
  wire next_irq1 = (irq_enable[3] && flags.soft_signal_flag_1) ||
    (irq_enable[1] && flags.monitor_hit_flag_1);
  wire next_irq0 = (irq_enable[2] && flags.soft_signal_flag_0) ||
    (irq_enable[0] && flags.monitor_hit_flag_0);

  ////////////////////////////////////////////////////////////////////////
  // Read mux. Reserved bits and the write-only control byte read zero.

  wire [7:0] status_byte = {irq_enable, flags};
  wire [7:0] base_lo_byte = {monitor_base_low_bits, monitor_enable,
    3'h0};
  logic [7:0] next_rdata;
  always_comb begin
    case (io_req.addr)
      `VLM_OFS_STATUS: next_rdata = status_byte;
      `VLM_OFS_BASE_HI: next_rdata = monitor_base_high_bits;
      `VLM_OFS_BASE_LO: next_rdata = base_lo_byte;
      `VLM_OFS_SEM_ONE: next_rdata = semaphore_value_one;
      `VLM_OFS_SEM_TWO: next_rdata = semaphore_value_two;
      `VLM_OFS_SLOT: next_rdata = {`VLM_READ_FILL, slot_sample};
      default: next_rdata = `VLM_RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags and enables.

  // The flags cleared by reset; the hit term outranks a same-cycle clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      flags <= '0;
      irq_enable <= `VLM_RST_NIBBLE;
    end else begin
      flags <= next_flags;
      if (wr_status) begin
        irq_enable <= io_req.wdata[7:4];
      end
    end
  end

  // Interrupt outputs are registered, so they trail the flags by one.
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_flag1 <= 1'b0;
      irq_flag0 <= 1'b0;
    end else begin
      irq_flag1 <= next_irq1;
      irq_flag0 <= next_irq0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Monitor base registers.

  always_ff @(posedge clk) begin
    if (reset) begin
      monitor_base_high_bits <= `VLM_RST_BYTE;
      monitor_base_low_bits <= `VLM_RST_NIBBLE;
      monitor_enable <= 1'b0;
    end else begin
      if (wr_base_hi) begin
        monitor_base_high_bits <= io_req.wdata;
      end
      if (wr_base_lo) begin
        monitor_base_low_bits <= io_req.wdata[7:4];
        monitor_enable <= io_req.wdata[`VLM_LO_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Semaphores. The test and the set happen in one write cycle, so two
  // masters cannot both see the lock clear and both take it.

  always_ff @(posedge clk) begin
    if (reset) begin
      semaphore_value_one <= `VLM_RST_BYTE;
      semaphore_value_two <= `VLM_RST_BYTE;
    end else begin
      if (wr_sem_one) begin
        semaphore_value_one <=
          sem_update(semaphore_value_one, io_req.wdata);
      end
      if (wr_sem_two) begin
        semaphore_value_two <=
          sem_update(semaphore_value_two, io_req.wdata);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot pins are sampled every cycle and have no reset value.

  always_ff @(posedge clk) begin
    slot_sample <= slot_addr_n;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data is registered and stands until the next read.

  always_ff @(posedge clk) begin
    if (reset) begin
      io_rdata <= `VLM_RST_BYTE;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= io_req.rd;
      if (io_req.rd) begin
        io_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Every reset, the mid-run one too, leaves status and outputs at zero.
  flag_reset_zero_a: assert property (
    $past(reset) |-> status_byte == 8'h00 && io_rdata == 8'h00 &&
    !io_rvalid && !irq_flag1 && !irq_flag0)
    else $error("status byte or outputs not zero after reset");

  irq1_signal_a: assert property (
    irq_enable[3] && flags.soft_signal_flag_1 |=> irq_flag1)
    else $error("signal 1 did not raise interrupt 1");

  irq0_signal_a: assert property (
    irq_enable[2] && flags.soft_signal_flag_0 |=> irq_flag0)
    else $error("signal 0 did not raise interrupt 0");

  irq1_monitor_a: assert property (
    irq_enable[1] && flags.monitor_hit_flag_1 |=> irq_flag1)
    else $error("monitor 1 did not raise interrupt 1");

  irq0_monitor_a: assert property (
    irq_enable[0] && flags.monitor_hit_flag_0 |=> irq_flag0)
    else $error("monitor 0 did not raise interrupt 0");

  irq_quiet_a: assert property (
    irq_enable == 4'h0 |=> !irq_flag1 && !irq_flag0)
    else $error("interrupt raised with all enables clear");

  sig_set_cause_a: assert property (
    $rose(flags.soft_signal_flag_1) |-> $past(wr_ctrl && io_req.wdata[7]))
    else $error("signal 1 set without control write");

  monitor_hit1_a: assert property (
    vme_probe.strobe && monitor_enable &&
    vme_probe.addr == {mon_base, 4'h3} |=> flags.monitor_hit_flag_1)
    else $error("offset 3 hit did not set monitor 1");

  monitor_hit0_a: assert property (
    vme_probe.strobe && monitor_enable &&
    vme_probe.addr == {mon_base, 4'h1} |=> flags.monitor_hit_flag_0)
    else $error("offset 1 hit did not set monitor 0");

  monitor_hold_a: assert property (
    $fell(flags.monitor_hit_flag_1) |-> $past(reset) ||
    $past(wr_ctrl && io_req.wdata[1]))
    else $error("monitor 1 cleared without clear write");

  base_write_a: assert property (
    wr_base_hi |=> monitor_base_high_bits == $past(io_req.wdata))
    else $error("upper base not written");

  monitor_off_a: assert property (
    !monitor_enable && !wr_ctrl ##1 !wr_ctrl
    |-> $stable(flags.monitor_hit_flag_1))
    else $error("monitor 1 changed while monitor disabled");

  sem_locked_a: assert property (
    wr_sem_one && semaphore_value_one[7] && io_req.wdata[7]
    |=> $stable(semaphore_value_one))
    else $error("locked semaphore one overwritten");

  sem_release_a: assert property (
    wr_sem_two && !io_req.wdata[7]
    |=> semaphore_value_two == $past(io_req.wdata))
    else $error("semaphore two release refused");

  set_clear_a: assert property (
    wr_ctrl && io_req.wdata[6] && io_req.wdata[2]
    |=> !flags.soft_signal_flag_0)
    else $error("set plus clear did not clear signal 0");

  soft_signal_flag_0_set_cause_a: assert property (
    $rose(flags.soft_signal_flag_0) |-> $past(wr_ctrl && io_req.wdata[6]))
    else $error("signal 0 set without control write");

  monitor0_hold_a: assert property (
    $fell(flags.monitor_hit_flag_0) |-> $past(reset) ||
    $past(wr_ctrl && io_req.wdata[0]))
    else $error("monitor 0 cleared without clear write");

  base_low_write_a: assert property (
    wr_base_lo |=> monitor_base_low_bits == $past(io_req.wdata[7:4]))
    else $error("lower base not written");

  monitor_enable_a: assert property (
    wr_base_lo |=> monitor_enable == $past(io_req.wdata[3]))
    else $error("monitor enable bit not written");

  slot_read_a: assert property (
    io_req.rd && io_req.addr == `VLM_OFS_SLOT
    |=> io_rdata == {2'h0, $past(slot_sample)})
    else $error("slot register read wrong");

  // A set without its clear must leave the flag set, whatever the hits do.
  ctrl_set_a: assert property (
    wr_ctrl && io_req.wdata[5] && !io_req.wdata[1]
    |=> flags.monitor_hit_flag_1)
    else $error("set write did not set monitor 1");

  read_answer_a: assert property (
    io_req.rd |=> io_rvalid)
    else $error("read not answered");

  monitor_hit_c: cover property (
    hit_1 ##1 flags.monitor_hit_flag_1 ##[1:4] irq_flag1);
  sem_refuse_c: cover property (
    wr_sem_one && semaphore_value_one[7] && io_req.wdata[7]);
  sig_irq_c: cover property (
    wr_ctrl && io_req.wdata[7] ##2 irq_flag1);
  hit_clear_race_c: cover property (hit_0 && clear_monitor_hit_0);

endmodule : vlm_regs

// >>> verification/vlm_vme_master.sv
// Behavioural VMEbus master that makes monitored address cycles.
`timescale 1ns/1ps

module vlm_vme_master (
  input wire logic clk, // System clock.
  output vlm_pkg::vlm_vme_probe_s vme_probe // Address cycle seen.
);
  // The bus starts idle with no strobe.
  initial begin
    vme_probe = '0;
  end

  // One address cycle; the strobe stands for exactly one edge.
  // A released bus shows the inverted address, so a stale copy never hits.
  task automatic hit(input logic [15:0] addr);
    @(posedge clk);
    #1;
    vme_probe.strobe = 1'b1;
    vme_probe.addr = addr;
    @(posedge clk);
    #1;
    vme_probe.strobe = 1'b0;
    vme_probe.addr = ~addr;
  endtask : hit
endmodule : vlm_vme_master

// >>> verification/vlm_regs_bench.sv
// Self-checking bench for the VME flag, monitor and semaphore block.
`timescale 1ns/1ps
`include "vlm_consts.svh"

module vlm_regs_bench;
  logic clk;
  logic reset;
  vlm_pkg::vlm_io_req_s io_req;
  logic [7:0] io_rdata;
  logic io_rvalid;
  vlm_pkg::vlm_vme_probe_s vme_probe;
  logic [5:0] slot_addr_n;
  logic irq_flag1;
  logic irq_flag0;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  vlm_regs u_vlm_regs (.clk(clk), .reset(reset), .io_req(io_req),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .vme_probe(vme_probe),
    .slot_addr_n(slot_addr_n), .irq_flag1(irq_flag1),
    .irq_flag0(irq_flag0));
  vlm_vme_master u_vlm_vme_master (.clk(clk), .vme_probe(vme_probe));

  ////////////////////////////////////////////////////////////////////////
  // Comparison and bus tasks.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One write; the request stands for a single edge.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    #1;
    io_req.wr = 1'b0;
  endtask : wr

  // One read; the answer pulse is looked at in its only cycle.
  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    io_req.rd = 1'b1;
    io_req.addr = a;
    @(posedge clk);
    #1;
    io_req.rd = 1'b0;
    chk({7'h00, io_rvalid}, 8'h01);
    chk(io_rdata, exp);
  endtask : rc

  // Interrupts trail their cause by one edge, so let that edge pass.
  task automatic irq(input logic e1, input logic e0);
    @(posedge clk);
    #1;
    chk({6'h00, irq_flag1, irq_flag0}, {6'h00, e1, e0});
  endtask : irq

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic test_reset();
    rc(`VLM_OFS_CTRL, 8'h00);
    rc(`VLM_OFS_STATUS, 8'h00);
    rc(`VLM_OFS_BASE_HI, 8'h00);
    rc(`VLM_OFS_BASE_LO, 8'h00);
    rc(`VLM_OFS_SEM_ONE, 8'h00);
    rc(`VLM_OFS_SEM_TWO, 8'h00);
    rc(`VLM_OFS_SLOT, 8'h15);
    slot_addr_n = 6'h2A;
    wr(`VLM_OFS_SLOT, 8'hFF);
    rc(`VLM_OFS_SLOT, 8'h2A);
    rc(16'h1007, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_signals();
    wr(`VLM_OFS_STATUS, 8'hFF);
    rc(`VLM_OFS_STATUS, 8'hF0);
    wr(`VLM_OFS_CTRL, 8'h80);
    irq(1'b1, 1'b0);
    wr(`VLM_OFS_CTRL, 8'h40);
    irq(1'b1, 1'b1);
    wr(`VLM_OFS_CTRL, 8'h00);
    rc(`VLM_OFS_STATUS, 8'hFC);
    wr(`VLM_OFS_CTRL, 8'h88);
    rc(`VLM_OFS_STATUS, 8'hF4);
    wr(`VLM_OFS_CTRL, 8'h04);
    irq(1'b0, 1'b0);
    wr(`VLM_OFS_CTRL, 8'h40);
    wr(`VLM_OFS_CTRL, 8'h44);
    rc(`VLM_OFS_STATUS, 8'hF0);
    wr(`VLM_OFS_STATUS, 8'h00);
    $display("test_signals done");
  endtask : test_signals

  task automatic test_monitor();
    wr(`VLM_OFS_STATUS, 8'h30);
    wr(`VLM_OFS_BASE_HI, 8'h12);
    wr(`VLM_OFS_BASE_LO, 8'h37);
    rc(`VLM_OFS_BASE_LO, 8'h30);
    u_vlm_vme_master.hit(16'h1233);
    rc(`VLM_OFS_STATUS, 8'h30);
    wr(`VLM_OFS_BASE_LO, 8'h38);
    u_vlm_vme_master.hit(16'h1232);
    u_vlm_vme_master.hit(16'h1333);
    rc(`VLM_OFS_STATUS, 8'h30);
    u_vlm_vme_master.hit(16'h1233);
    irq(1'b1, 1'b0);
    u_vlm_vme_master.hit(16'h1231);
    irq(1'b1, 1'b1);
    wr(`VLM_OFS_CTRL, 8'h0C);
    rc(`VLM_OFS_STATUS, 8'h33);
    wr(`VLM_OFS_CTRL, 8'h03);
    rc(`VLM_OFS_STATUS, 8'h30);
    // A hit on the edge of a clear write must leave the flag set.
    fork
      u_vlm_vme_master.hit(16'h1231);
      wr(`VLM_OFS_CTRL, 8'h01);
    join
    rc(`VLM_OFS_STATUS, 8'h31);
    wr(`VLM_OFS_CTRL, 8'h30);
    rc(`VLM_OFS_STATUS, 8'h33);
    wr(`VLM_OFS_CTRL, 8'h03);
    irq(1'b0, 1'b0);
    $display("test_monitor done");
  endtask : test_monitor

  // The second semaphore starts free while the first stays locked.
  task automatic test_sem();
    logic [15:0] a;
    for (int i = 0; i < 2; i++) begin
      a = `VLM_OFS_SEM_ONE + 16'(i);
      wr(a, 8'h81);
      rc(a, 8'h81);
      wr(a, 8'hC5);
      rc(a, 8'h81);
      wr(a, 8'h05);
      rc(a, 8'h05);
      wr(a, 8'hC5);
      rc(a, 8'hC5);
    end
    @(posedge clk);
    #1;
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    rc(`VLM_OFS_SEM_ONE, 8'h00);
    rc(`VLM_OFS_SEM_TWO, 8'h00);
    rc(`VLM_OFS_STATUS, 8'h00);
    rc(`VLM_OFS_BASE_LO, 8'h00);
    $display("test_sem done");
  endtask : test_sem

  ////////////////////////////////////////////////////////////////////////
  // Verdict, clock, main sequence and hang guard.
  task automatic close_out();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Reset is held for sixteen edges before any request.
  initial begin
    reset = 1'b1;
    io_req = '0;
    slot_addr_n = 6'h15;
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    test_reset();
    test_signals();
    test_monitor();
    test_sem();
    close_out();
  end

  // The scenarios need about 150 edges; 2000 means a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      close_out();
    end
  end
endmodule : vlm_regs_bench
